// [hdl/sbl_map.vh]
`ifndef SBL_MAP_VH
`define SBL_MAP_VH
// Register byte offsets
`define SBL_ENR_OFF 8'h00
`define SBL_FC1_OFF 8'h04
`define SBL_FS2_OFF 8'h08
`define SBL_EBS_OFF 8'h0c
`define SBL_FPC_OFF 8'h10
`define SBL_STAT_OFF 8'h14
`define SBL_BAUD_OFF 8'h18
`define SBL_SCTL_OFF 8'h1c
// Field positions
`define SBL_ACC_BIT 7
`define SBL_TE_BIT 0
`define SBL_RE_BIT 1
`define SBL_ST_LEN_LSB 16
// Reset values
`define SBL_RST8 8'h00
`define SBL_BAUD_RST 20'h0043c
// Timing, in system-clock states
`define SBL_READY_STATES 100
`define SBL_SYNC_STATES 2
// Rate measurement
`define SBL_BITS_PER_ZERO 20'h00009
// Program RAM window
`define SBL_RAM_FIRST 16'hf780
`define SBL_RAM_LAST 16'hfeef
// Handshake bytes
`define SBL_B_DONE 8'h00
`define SBL_B_SYNC 8'h55
`define SBL_B_OK 8'haa
`define SBL_B_ERR 8'hff
`endif

// [hdl/sbl_uart.v]
`timescale 1ns/1ps
module sbl_uart #(
  parameter W = 20
) (
  input  wire         ref_clk,
  input  wire         rstn,
  input  wire [W-1:0] bit_cyc,
  input  wire         rx_en,
  input  wire         rx,
  output reg          rx_valid,
  output reg  [7:0]   rx_data,
  input  wire         tx_en,
  input  wire         tx_go,
  input  wire [7:0]   tx_data,
  output reg          tx_done,
  output reg          txd
);
  reg         rbusy;
  reg [W-1:0] rcnt;
  reg [3:0]   rbit;
  reg [7:0]   rsh;
  reg         tbusy;
  reg [W-1:0] tcnt;
  reg [3:0]   tbit;
  reg [9:0]   tsh;

  ////////////////////////////////////////////////////////////
  // Receiver, 8 data bits, 1 stop, no parity
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rbusy    <= 1'b0;
      rcnt     <= {W{1'b0}};
      rbit     <= 4'h0;
      rsh      <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rbusy) begin
        if (rx_en && !rx) begin
          rbusy <= 1'b1;
          rcnt  <= bit_cyc >> 1;
          rbit  <= 4'h0;
        end
      end else if (rcnt != {W{1'b0}}) begin
        rcnt <= rcnt - 1'b1;
      end else begin
        rcnt <= bit_cyc - 1'b1;
        if (rbit == 4'h0) begin
          // Glitch, not a start bit
          if (rx)
            rbusy <= 1'b0;
          rbit <= 4'h1;
        end else if (rbit <= 4'h8) begin
          rsh  <= {rx, rsh[7:1]};
          rbit <= rbit + 1'b1;
        end else begin
          rbusy <= 1'b0;
          // Framing error drops the byte
          if (rx) begin
            rx_valid <= 1'b1;
            rx_data  <= rsh;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Transmitter, line idles high
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tbusy   <= 1'b0;
      tcnt    <= {W{1'b0}};
      tbit    <= 4'h0;
      tsh     <= 10'h3ff;
      tx_done <= 1'b0;
      txd     <= 1'b1;
    end else begin
      tx_done <= 1'b0;
      if (!tbusy) begin
        if (tx_go && tx_en) begin
          tsh   <= {1'b1, tx_data, 1'b0};
          tbusy <= 1'b1;
          tcnt  <= bit_cyc - 1'b1;
          tbit  <= 4'h0;
          txd   <= 1'b0;
        end
      end else if (tcnt != {W{1'b0}}) begin
        tcnt <= tcnt - 1'b1;
      end else if (tbit == 4'h9) begin
        tbusy   <= 1'b0;
        tx_done <= 1'b1;
        txd     <= 1'b1;
      end else begin
        tsh  <= {1'b1, tsh[9:1]};
        txd  <= tsh[1];
        tbit <= tbit + 1'b1;
        tcnt <= bit_cyc - 1'b1;
      end
    end
  end
endmodule

// [hdl/sbl_loader.v]
`timescale 1ns/1ps
`include "sbl_map.vh"

// How it works
// - Flash control registers answer only while the access bit is one
// - Reserved bits 6..0 of the access-enable register read zero
// - Mode taken from straps at reset release: user, boot or programmer
// - Boot serial link is 8 data bits, one stop, no parity
// - Boot measures low time of host zero bytes, sets baud to match
// - Measurement starts about 100 states after reset release
// - Device sends zero byte when matched; host answers 0x55
// - Erase flash if written, then send 0xAA; on failure 0xFF and stop
// - Length arrives high byte first; each byte echoed
// - Program bytes echoed and stored in order; 0xAA after the last
// - Program goes into RAM window ending at 0xFEEF
// - After transfer the loaded program is started
// - Before branch clear serial enables, keep baud, drive transmit high
// - Watchdog overflow also ends boot mode
module sbl_loader #(
  parameter BW  = 20,
  parameter AW  = 11
) (
  input  wire          ref_clk,
  input  wire          rstn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          test_pin,
  input  wire          boot_select_pin,
  input  wire          boot_confirm_pin,
  input  wire          programmer_select_pin_a,
  input  wire          programmer_select_pin_b,
  input  wire          programmer_select_pin_c,
  input  wire          rxd,
  output wire          txd,
  output reg           txd_oe,
  input  wire          flash_written,
  input  wire          erase_done,
  input  wire          erase_fail,
  input  wire          flash_error,
  input  wire          wdt_overflow,
  output reg           erase_req,
  output reg  [7:0]    flash_control_one,
  output reg  [4:0]    erase_block_select,
  output reg           flash_power_control,
  output reg           mode_user,
  output reg           mode_boot,
  output reg           mode_prog,
  output reg           branch,
  input  wire [AW-1:0] ram_raddr,
  output reg  [7:0]    ram_rdata
);
  localparam DEPTH = `SBL_RAM_LAST - `SBL_RAM_FIRST + 1;
  localparam READY_CYC = `SBL_READY_STATES;
  localparam S_STRAP = 4'h0;
  localparam S_WAIT  = 4'h1;
  localparam S_MEAS  = 4'h2;
  localparam S_LOW   = 4'h3;
  localparam S_DIV   = 4'h4;
  localparam S_SYNC  = 4'h5;
  localparam S_ERASE = 4'h6;
  localparam S_ERW   = 4'h7;
  localparam S_LENH  = 4'h8;
  localparam S_LENL  = 4'h9;
  localparam S_DATA  = 4'ha;
  localparam S_GO    = 4'hb;
  localparam S_RUN   = 4'hc;
  localparam S_ABORT = 4'hd;
  localparam S_IDLE  = 4'he;
  localparam S_TX    = 4'hf;

  reg [5:0]    strap_m;
  reg [5:0]    strap_s;
  reg          rx_m;
  reg          rx_s;
  reg          acc_en;
  reg [3:0]    state;
  reg [3:0]    ret;
  reg [BW-1:0] cnt;
  reg [BW-1:0] quo;
  reg [BW-1:0] baud;
  reg          re;
  reg          te;
  reg          tx_go;
  reg [7:0]    tx_byte;
  reg [15:0]   len;
  reg [15:0]   bcnt;
  reg          aborted;
  reg [31:0]   rd;
  reg [7:0]    mem [0:DEPTH-1];
  wire         rx_valid;
  wire [7:0]   rx_data;
  wire         tx_done;
  wire         err_now;
  wire         wr_ok;
  wire         sw_own;
  wire         ram_we;

  ////////////////////////////////////////////////////////////
  // Address decode helpers
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `SBL_SCTL_OFF);
    end
  endfunction

  function gated;
    input [7:0] a;
    begin
      gated = (a == `SBL_FC1_OFF) || (a == `SBL_FS2_OFF) ||
              (a == `SBL_EBS_OFF) || (a == `SBL_FPC_OFF);
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // Pin synchronisers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_m <= 6'h00;
      strap_s <= 6'h00;
      rx_m    <= 1'b1;
      rx_s    <= 1'b1;
    end else begin
      strap_m <= {test_pin, boot_select_pin, boot_confirm_pin,
                  programmer_select_pin_a, programmer_select_pin_b,
                  programmer_select_pin_c};
      strap_s <= strap_m;
      rx_m    <= rxd;
      rx_s    <= rx_m;
    end
  end

  ////////////////////////////////////////////////////////////
  // APB slave, one wait state
  assign err_now = !mapped(paddr) || (gated(paddr) && !acc_en);
  assign wr_ok   = psel && penable && pready && pwrite && !err_now;
  assign sw_own  = (state == S_RUN) || (state == S_IDLE);

  always @* begin
    rd = 32'h00000000;
    case (paddr)
      `SBL_ENR_OFF:  rd = {24'h000000, acc_en, 7'h00};
      `SBL_FC1_OFF:  rd = {24'h000000, flash_control_one};
      `SBL_FS2_OFF:  rd = {24'h000000, flash_error, 7'h00};
      `SBL_EBS_OFF:  rd = {27'h0000000, erase_block_select};
      `SBL_FPC_OFF:  rd = {24'h000000, flash_power_control, 7'h00};
      `SBL_STAT_OFF: rd = {len, 7'h00, aborted, state, branch,
                           mode_prog, mode_boot, mode_user};
      `SBL_BAUD_OFF: rd = {{(32-BW){1'b0}}, baud};
      `SBL_SCTL_OFF: rd = {30'h00000000, re, te};
      default:       rd = 32'h00000000;
    endcase
    // Blocked or unmapped reads return zero
    if (err_now)
      rd = 32'h00000000;
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      prdata              <= 32'h00000000;
      acc_en              <= 1'b0;
      flash_control_one   <= `SBL_RST8;
      erase_block_select  <= 5'h00;
      flash_power_control <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= err_now;
        prdata  <= rd;
      end
      if (wr_ok) begin
        case (paddr)
          `SBL_ENR_OFF: acc_en <= pwdata[`SBL_ACC_BIT];
          `SBL_FC1_OFF: flash_control_one <= pwdata[7:0];
          `SBL_EBS_OFF: erase_block_select <= pwdata[4:0];
          `SBL_FPC_OFF: flash_power_control <= pwdata[7];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Serial engine, never inverts either line
  sbl_uart #(
    .W (BW)
  ) u_uart (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .bit_cyc  (baud),
    .rx_en    (re),
    .rx       (rx_s),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_en    (te),
    .tx_go    (tx_go),
    .tx_data  (tx_byte),
    .tx_done  (tx_done),
    .txd      (txd)
  );

  ////////////////////////////////////////////////////////////
  // Boot sequencer
  task send;
    input [7:0] b;
    input [3:0] r;
    begin
      tx_byte <= b;
      tx_go   <= 1'b1;
      ret     <= r;
      state   <= S_TX;
    end
  endtask

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= S_STRAP;
      ret       <= S_STRAP;
      cnt       <= {BW{1'b0}};
      quo       <= {BW{1'b0}};
      baud      <= `SBL_BAUD_RST;
      re        <= 1'b0;
      te        <= 1'b0;
      tx_go     <= 1'b0;
      tx_byte   <= 8'h00;
      len       <= 16'h0000;
      bcnt      <= 16'h0000;
      aborted   <= 1'b0;
      erase_req <= 1'b0;
      txd_oe    <= 1'b0;
      mode_user <= 1'b0;
      mode_boot <= 1'b0;
      mode_prog <= 1'b0;
      branch    <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      if (sw_own && wr_ok && paddr == `SBL_BAUD_OFF)
        baud <= pwdata[BW-1:0];
      if (sw_own && wr_ok && paddr == `SBL_SCTL_OFF) begin
        re <= pwdata[`SBL_RE_BIT];
        te <= pwdata[`SBL_TE_BIT];
      end
      case (state)
        S_STRAP: begin
          // Straps sampled once the synchroniser has filled
          cnt <= cnt + 1'b1;
          if (cnt == `SBL_SYNC_STATES) begin
            state <= S_WAIT;
            if (!strap_s[5] && strap_s[4])
              mode_user <= 1'b1;
            else if (!strap_s[5] && !strap_s[4] && strap_s[3])
              mode_boot <= 1'b1;
            else if (strap_s[5] && strap_s[2:0] == 3'b000)
              mode_prog <= 1'b1;
            else
              mode_user <= 1'b1;
          end
        end
        S_WAIT: begin
          cnt <= cnt + 1'b1;
          if (cnt == READY_CYC) begin
            cnt <= {BW{1'b0}};
            if (mode_boot) begin
              state  <= S_MEAS;
              txd_oe <= 1'b1;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_MEAS: begin
          cnt <= {BW{1'b0}};
          if (!rx_s)
            state <= S_LOW;
        end
        S_LOW: begin
          if (cnt != {BW{1'b1}})
            cnt <= cnt + 1'b1;
          if (rx_s) begin
            quo   <= {BW{1'b0}};
            state <= S_DIV;
          end
        end
        S_DIV: begin
          // Repeated subtraction: slow but tiny, runs once per low-time measurement
          if (cnt >= `SBL_BITS_PER_ZERO) begin
            cnt <= cnt - `SBL_BITS_PER_ZERO;
            quo <= quo + 1'b1;
          end else if (quo < 20'h00004) begin
            state <= S_MEAS;
          end else begin
            baud <= quo;
            re   <= 1'b1;
            te   <= 1'b1;
            send(`SBL_B_DONE, S_SYNC);
          end
        end
        S_SYNC: begin
          // Trailing zero bytes from the host are skipped
          if (rx_valid && rx_data == `SBL_B_SYNC)
            state <= S_ERASE;
        end
        S_ERASE: begin
          if (flash_written) begin
            erase_req <= 1'b1;
            state     <= S_ERW;
          end else begin
            send(`SBL_B_OK, S_LENH);
          end
        end
        S_ERW: begin
          if (erase_fail) begin
            erase_req <= 1'b0;
            aborted   <= 1'b1;
            send(`SBL_B_ERR, S_ABORT);
          end else if (erase_done) begin
            erase_req <= 1'b0;
            send(`SBL_B_OK, S_LENH);
          end
        end
        S_LENH: begin
          if (rx_valid) begin
            len[15:8] <= rx_data;
            send(rx_data, S_LENL);
          end
        end
        S_LENL: begin
          if (rx_valid) begin
            len[7:0] <= rx_data;
            bcnt     <= 16'h0000;
            send(rx_data, S_DATA);
          end
        end
        S_DATA: begin
          if (bcnt == len) begin
            send(`SBL_B_OK, S_GO);
          end else if (rx_valid) begin
            bcnt <= bcnt + 1'b1;
            send(rx_data, S_DATA);
          end
        end
        S_GO: begin
          re     <= 1'b0;
          te     <= 1'b0;
          txd_oe <= 1'b1;
          branch <= 1'b1;
          state  <= S_RUN;
        end
        S_RUN: state <= S_RUN;
        S_ABORT: begin
          re <= 1'b0;
          te <= 1'b0;
        end
        S_IDLE: state <= S_IDLE;
        S_TX: begin
          if (tx_done)
            state <= ret;
        end
        default: state <= S_IDLE;
      endcase
      // Watchdog ends boot from any loader step
      if (wdt_overflow && mode_boot && !branch) begin
        mode_boot <= 1'b0;
        re        <= 1'b0;
        te        <= 1'b0;
        erase_req <= 1'b0;
        state     <= S_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Program RAM; bytes past the window are echoed but dropped
  assign ram_we = (state == S_DATA) && rx_valid && (bcnt != len) &&
                  (bcnt < DEPTH);

  always @(posedge ref_clk) begin
    if (ram_we)
      mem[bcnt[AW-1:0]] <= rx_data;
    ram_rdata <= mem[ram_raddr];
  end
endmodule

// [bench/sbl_loader_props.sv]
`timescale 1ns/1ps
module sbl_loader_props (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        test_pin,
  input wire logic        boot_select_pin,
  input wire logic        boot_confirm_pin,
  input wire logic        programmer_select_pin_a,
  input wire logic        programmer_select_pin_b,
  input wire logic        programmer_select_pin_c,
  input wire logic        txd,
  input wire logic        txd_oe,
  input wire logic        erase_req,
  input wire logic        erase_done,
  input wire logic        erase_fail,
  input wire logic        wdt_overflow,
  input wire logic        mode_user,
  input wire logic        mode_boot,
  input wire logic        mode_prog,
  input wire logic        branch,
  input wire logic [7:0]  flash_control_one
);
  // Shadow of the access bit, rebuilt from completed writes
  logic acc;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      acc <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      acc <= pwdata[7];
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence apb_req;
    psel && penable && !pready;
  endsequence
  sequence apb_gated;
    psel && penable && pready && !acc && paddr >= 8'h04 && paddr <= 8'h10 && paddr[1:0] == 2'b00;
  endsequence
  AST_APB_WAIT: assert property (apb_req |=> pready) else $error("pready late");
  AST_APB_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_GATE_ERR: assert property (apb_gated |-> pslverr && prdata == 32'h0) else $error("gated access open");
  AST_GATE_WR: assert property (apb_gated ##0 pwrite |=> $stable(flash_control_one)) else $error("gated write");
  AST_RSVD: assert property (psel && penable && pready && !pwrite && paddr == 8'h00
    |-> prdata == {24'h0, acc, 7'h00}) else $error("enable reg read");
  AST_MODE: assert property ($rose(rstn) |-> ##[1:5] $onehot({mode_user, mode_boot, mode_prog}))
    else $error("no mode");
  AST_STRAP: assert property ((!mode_boot || (!test_pin && !boot_select_pin && boot_confirm_pin)) &&
    (!mode_prog || (test_pin && !programmer_select_pin_a && !programmer_select_pin_b && !programmer_select_pin_c)))
    else $error("mode strap");
  AST_ERASE: assert property (erase_req && (erase_done || erase_fail) |-> ##[1:3] !erase_req)
    else $error("erase req stuck");
  AST_WDT: assert property (mode_boot && !branch && wdt_overflow |-> ##[1:3] !mode_boot)
    else $error("watchdog ignored");
  AST_BRANCH_TX: assert property (branch |-> txd && txd_oe) else $error("txd not high");
  AST_BRANCH_HOLD: assert property (branch |=> branch) else $error("branch lost");
endmodule

// [bench/sbl_host.sv]
`timescale 1ns/1ps
module sbl_host #(
  parameter BIT = 16
) (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  // Idle high so no false start bit at reset release
  initial rxd = 1'b1;
  // 8N1, LSB first, no inverter on the line
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
  endtask
  // Bad stop bit or silence returns unknown
  task automatic recv(output logic [7:0] b);
    int n;
    b = 8'hxx;
    n = 0;
    while (txd !== 1'b0 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n < 20000) begin
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge ref_clk);
      if (txd !== 1'b1)
        b = 8'hxx;
    end
  endtask
endmodule

// [bench/sbl_loader_tb.sv]
`timescale 1ns/1ps
`include "sbl_map.vh"
bind sbl_loader sbl_loader_props u_props (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .test_pin, .boot_select_pin, .boot_confirm_pin, .programmer_select_pin_a,
  .programmer_select_pin_b, .programmer_select_pin_c, .txd, .txd_oe, .erase_req, .erase_done, .erase_fail,
  .wdt_overflow, .mode_user, .mode_boot, .mode_prog, .branch, .flash_control_one);
module sbl_loader_tb;
  localparam BIT = 16;
  logic        ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, flash_control_one, ram_rdata, sb;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, rxd, txd, txd_oe, erase_req, mode_user, mode_boot, mode_prog, branch;
  logic        test_pin = 1'b0, boot_select_pin = 1'b0, boot_confirm_pin = 1'b1;
  logic        programmer_select_pin_a = 1'b1, programmer_select_pin_b = 1'b1, programmer_select_pin_c = 1'b1;
  logic        flash_written = 1'b1, erase_done = 1'b0, erase_fail = 1'b0, flash_error = 1'b0;
  logic        wdt_overflow = 1'b0, fail_erase = 1'b0, got = 1'b0, flash_power_control;
  logic [4:0]  erase_block_select;
  logic [10:0] ram_raddr = 11'h000;
  logic [7:0]  prog [3] = '{8'ha5, 8'h3c, 8'hc3};
  logic [5:0]  straps [4] = '{6'b011111, 6'b001111, 6'b110000, 6'b000000};
  logic [2:0]  modes [4] = '{3'b100, 3'b010, 3'b001, 3'b100};
  int          bad_count = 0, cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  // Flash answers one cycle after the request; fail_erase picks the outcome
  always @(posedge ref_clk) begin
    erase_done <= erase_req && !erase_done && !fail_erase;
    erase_fail <= erase_req && !erase_fail && fail_erase;
  end
  sbl_loader DUT (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .test_pin, .boot_select_pin, .boot_confirm_pin, .programmer_select_pin_a, .programmer_select_pin_b,
    .programmer_select_pin_c, .rxd, .txd, .txd_oe, .flash_written, .erase_done, .erase_fail, .flash_error,
    .wdt_overflow, .erase_req, .flash_control_one, .erase_block_select, .flash_power_control, .mode_user,
    .mode_boot, .mode_prog, .branch, .ram_raddr, .ram_rdata);
  sbl_host #(.BIT(BIT)) u_host (.ref_clk, .txd, .rxd);
  ////////////////////////////////////////////////////////////////
  task stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got_v, exp_v);
    end
  endtask
  // Waits for pready as long as it takes; only the global time limit ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Straps change only while reset is low and settle long before release
  task rst(input logic [5:0] s, input int c);
    @(posedge ref_clk);
    rstn <= 1'b0;
    {test_pin, boot_select_pin, boot_confirm_pin, programmer_select_pin_a, programmer_select_pin_b,
      programmer_select_pin_c} <= s;
    repeat (c) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  task xfer(input logic [7:0] b, input logic [7:0] e);
    fork
      u_host.send(b);
      u_host.recv(sb);
    join
    chk(sb, e);
  endtask
  // Zeros until the device answers; waits past the arming delay first
  task sync;
    repeat (120) @(posedge ref_clk);
    got = 1'b0;
    fork
      while (!got) u_host.send(8'h00);
      begin
        u_host.recv(sb);
        got = 1'b1;
      end
    join
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int n;
    rst(6'b001111, 8);
    apb(0, 8'h00, 0); chk(rd, 32'h0);
    apb(1, 8'h18, 32'h20); apb(0, 8'h18, 0); chk(rd, `SBL_BAUD_RST);
    apb(1, 8'h04, 32'h5a); chk(er, 1'b1);
    chk(flash_control_one, 8'h00);
    apb(1, 8'h00, 32'hffffffff); apb(0, 8'h00, 0); chk(rd, 32'h80);
    apb(1, 8'h04, 32'h5a); apb(0, 8'h04, 0); chk(rd, 32'h5a);
    chk(flash_control_one, 8'h5a);
    apb(1, 8'h0c, 32'hff); apb(0, 8'h0c, 0); chk(rd, 32'h1f);
    chk(erase_block_select, 5'h1f);
    apb(1, 8'h10, 32'hff); apb(0, 8'h10, 0); chk(rd, 32'h80);
    chk(flash_power_control, 1'b1);
    apb(1, 8'h00, 32'h0); apb(0, 8'h0c, 0); chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(0, 8'h20, 0); chk(er, 1'b1);
    sync; chk(sb, `SBL_B_DONE);
    apb(0, 8'h18, 0); chk(rd, BIT);
    xfer(`SBL_B_SYNC, `SBL_B_OK);
    xfer(8'h00, 8'h00);
    xfer(8'h03, 8'h03);
    for (int i = 0; i < 3; i++) xfer(prog[i], prog[i]);
    u_host.recv(sb); chk(sb, `SBL_B_OK);
    for (n = 0; branch !== 1'b1 && n < 200; n++) @(posedge ref_clk);
    chk(branch, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ram_raddr <= i;
      repeat (2) @(posedge ref_clk);
      chk(ram_rdata, prog[i]);
    end
    apb(0, 8'h1c, 0); chk(rd, 32'h0);
    apb(0, 8'h18, 0); chk(rd, BIT);
    chk({txd, txd_oe}, 2'b11);
    apb(1, 8'h1c, 32'h3); apb(0, 8'h1c, 0); chk(rd, 32'h3);
    rst(6'b001111, 24);
    fail_erase <= 1'b1;
    sync; chk(sb, `SBL_B_DONE);
    xfer(`SBL_B_SYNC, `SBL_B_ERR);
    // Blank flash: no erase, so a failing flash must not matter
    rst(6'b001111, 24);
    flash_written <= 1'b0;
    sync; chk(sb, `SBL_B_DONE);
    if (sb !== `SBL_B_DONE) rst(6'b001111, 24);
    xfer(`SBL_B_SYNC, `SBL_B_OK);
    flash_written <= 1'b1;
    fail_erase <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rst(straps[i], 24);
      chk({mode_user, mode_boot, mode_prog}, modes[i]);
    end
    rst(6'b001111, 24);
    chk(mode_boot, 1'b1);
    wdt_overflow <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(mode_boot, 1'b0);
    stop_test;
  end
  // Whole run is well under 20k cycles
  initial begin
    #400000;
    bad_count++;
    stop_test;
  end
endmodule
